// ---- design/adc_seq_pkg.sv ----
package adc_seq_pkg;
    // Register byte offsets
    localparam logic [11:0] CTRL0_OFS = 12'h000;
    localparam logic [11:0] CTRL1_OFS = 12'h004;
    localparam logic [11:0] CTRL2_OFS = 12'h008;
    localparam logic [11:0] STAT_OFS = 12'h00C;
    localparam logic [11:0] RES_BASE_OFS = 12'h010;
    localparam logic [11:0] RES_LAST_OFS = 12'h02C;
    // Control 0 fields
    localparam int CH_LSB = 0;
    localparam int MODE_LSB = 3;
    localparam int EXT_TRIG_BIT = 6;
    localparam int START_BIT = 7;
    // Control 1 fields
    localparam int DIV_LSB = 0;
    localparam int RES10_BIT = 3;
    localparam int LADDER_BIT = 5;
    localparam int EXTA_BIT = 6;
    localparam int EXTB_BIT = 7;
    // Control 2 fields
    localparam int SH_BIT = 0;
    // Status fields
    localparam int BUSY_BIT = 0;
    localparam int LAST_CH_LSB = 4;
    // Field widths and reset values
    localparam int CH_W = 3;
    localparam int MODE_W = 3;
    localparam int DIV_W = 2;
    localparam int AIN_W = 4;
    localparam int RES_W = 10;
    localparam int CNT_W = 7;
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    // Operating modes
    localparam logic [2:0] MODE_ONE_SHOT = 3'h0;
    localparam logic [2:0] MODE_REPEAT = 3'h1;
    localparam logic [2:0] MODE_SINGLE_SWEEP = 3'h2;
    localparam logic [2:0] MODE_REP_SWEEP0 = 3'h3;
    localparam logic [2:0] MODE_REP_SWEEP1 = 3'h4;
    // Conversion clock divider codes
    localparam logic [1:0] DIV_BY4 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [1:0] DIV_BY1 = 2'h2;
    localparam logic [1:0] DIV_LIM4 = 2'h3;
    localparam logic [1:0] DIV_LIM2 = 2'h1;
    localparam logic [1:0] DIV_LIM1 = 2'h0;
    // Conversion clock cycles per channel
    localparam logic [6:0] CYC_8 = 7'd49;
    localparam logic [6:0] CYC_10 = 7'd59;
    localparam logic [6:0] CYC_SH8 = 7'd28;
    localparam logic [6:0] CYC_SH10 = 7'd33;
    localparam logic [3:0] BITS_8 = 4'd8;
    localparam logic [3:0] BITS_10 = 4'd10;
    localparam logic [9:0] MSB_8 = 10'h080;
    localparam logic [9:0] MSB_10 = 10'h200;
    localparam int NUM_SLOTS = 8;
    // Extended input codes on the analog select
    localparam logic [3:0] AIN_EXT_A = 4'h8;
    localparam logic [3:0] AIN_EXT_B = 4'h9;
    localparam logic [2:0] RES_IDX_EXT_A = 3'h0;
    localparam logic [2:0] RES_IDX_EXT_B = 3'h1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } eng_state_t;
endpackage

// ---- design/conv_if.sv ----
`timescale 1ns/1ns
interface conv_if;
    import adc_seq_pkg::*;
    logic [DIV_W-1:0] div_sel;
    logic tick;
    logic start;
    logic abort;
    logic res10;
    logic sh_on;
    logic busy;
    logic done;
    logic sample;
    logic [RES_W-1:0] dac_code;
    logic [RES_W-1:0] result;

    modport ctrl (output div_sel, output start, output abort, output res10, output sh_on,
        input tick, input busy, input done, input sample, input dac_code, input result);
    modport div (input div_sel, output tick);
    modport eng (input tick, input start, input abort, input res10, input sh_on,
        output busy, output done, output sample, output dac_code, output result);
endinterface

// ---- design/conv_clk_div.sv ----
`timescale 1ns/1ns
module conv_clk_div
    import adc_seq_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    conv_if.div cif
);
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic [1:0] lim;

    always_comb begin
        case (cif.div_sel)
            DIV_BY1: lim = DIV_LIM1;
            DIV_BY2: lim = DIV_LIM2;
            default: lim = DIV_LIM4;
        endcase
        next_cnt = (cnt >= lim) ? 2'h0 : cnt + 2'h1;
    end

    // Tick marks one conversion clock period
    assign cif.tick = (cnt >= lim);

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 2'h0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule

// ---- design/sar_engine.sv ----
`timescale 1ns/1ns
module sar_engine
    import adc_seq_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic cmp_i,
    conv_if.eng cif
);
    eng_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt, total, next_total;
    logic [3:0] nbits, next_nbits;
    logic [RES_W-1:0] sar, next_sar, mask, next_mask, dac, next_dac;
    logic done, next_done;
    logic [CNT_W-1:0] bit_start;

    assign bit_start = total - {3'h0, nbits};

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_total = total;
        next_nbits = nbits;
        next_sar = sar;
        next_mask = mask;
        next_done = 1'b0;
        if (cif.start) begin
            // Cycle count fixed at start, so a mid-conversion resolution or sample-hold write cannot skew it
            next_state = ST_CONV;
            next_cnt = '0;
            next_sar = '0;
            next_nbits = cif.res10 ? BITS_10 : BITS_8;
            next_mask = cif.res10 ? MSB_10 : MSB_8;
            case ({cif.sh_on, cif.res10})
                2'b00: next_total = CYC_8;
                2'b01: next_total = CYC_10;
                2'b10: next_total = CYC_SH8;
                default: next_total = CYC_SH10;
            endcase
        end else if (cif.abort) begin
            next_state = ST_IDLE;
        end else begin
            case (state)
                ST_CONV: begin
                    if (cif.tick) begin
                        next_cnt = cnt + 7'd1;
                        if (cnt >= bit_start) begin
                            if (cmp_i) begin
                                next_sar = sar | mask;
                            end
                            next_mask = mask >> 1;
                        end
                        if (cnt == total - 7'd1) begin
                            next_state = ST_IDLE;
                            next_done = 1'b1;
                        end
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
        next_dac = next_sar | next_mask;
    end

    assign cif.busy = (state == ST_CONV);
    assign cif.done = done;
    assign cif.sample = (state == ST_CONV) && (cnt < bit_start);
    assign cif.dac_code = dac;
    assign cif.result = sar;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            cnt <= '0;
            total <= CYC_8;
            nbits <= BITS_8;
            sar <= '0;
            mask <= '0;
            dac <= '0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            total <= next_total;
            nbits <= next_nbits;
            sar <= next_sar;
            mask <= next_mask;
            dac <= next_dac;
            done <= next_done;
        end
    end
endmodule

// ---- design/adc_seq_top.sv ----
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
module adc_seq_top
    import adc_seq_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ext_conv_trigger_in_i,
    input wire logic cmp_i,
    output logic ladder_connect_o,
    output logic [AIN_W-1:0] ain_sel_o,
    output logic sample_o,
    output logic [RES_W-1:0] dac_code_o,
    output logic conv_irq_o
);
    conv_if cif();

    conv_clk_div u_div (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .cif(cif.div)
    );

    sar_engine u_eng (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .cmp_i(cmp_i),
        .cif(cif.eng)
    );

    function automatic logic is_res_addr(input logic [11:0] a);
        is_res_addr = (a >= RES_BASE_OFS) && (a <= RES_LAST_OFS) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == CTRL0_OFS) || (a == CTRL1_OFS) || (a == CTRL2_OFS) ||
            (a == STAT_OFS) || is_res_addr(a);
    endfunction

    function automatic logic repeats(input logic [MODE_W-1:0] m);
        repeats = (m == MODE_REPEAT) || (m == MODE_REP_SWEEP0) || (m == MODE_REP_SWEEP1);
    endfunction

    logic [7:0] ctrl0;
    logic [7:0] next_ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] next_ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] next_ctrl2;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [RES_W-1:0] res_mem [NUM_SLOTS];
    logic [RES_W-1:0] next_res_mem [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] res_we;
    logic [CH_W-1:0] cur_idx;
    logic [CH_W-1:0] next_cur_idx;
    logic [MODE_W-1:0] cur_mode;
    logic [MODE_W-1:0] next_cur_mode;
    logic cur_ext;
    logic next_cur_ext;
    logic [AIN_W-1:0] ain;
    logic [AIN_W-1:0] next_ain;
    logic irq;
    logic next_irq;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic trig_lvl;
    logic next_trig_lvl;
    logic trig_fall;
    logic bus_access;
    logic bus_write;
    logic bus_setup_rd;
    logic wr_ctrl0;
    logic sw_start;
    logic ext_start;
    logic rearm;
    logic stop;
    logic [11:0] idx_ofs;
    logic [CH_W-1:0] sel_ch;
    logic [MODE_W-1:0] sel_mode;
    logic sel_ext;

    assign bus_access = psel_i && penable_i;
    assign bus_write = bus_access && pwrite_i;
    assign bus_setup_rd = psel_i && !penable_i && !pwrite_i;
    // Zero wait states: every access ends in its first access cycle
    assign pready_o = 1'b1;
    assign pslverr_o = bus_access && !is_mapped(paddr_i);
    assign prdata_o = rdata;
    assign wr_ctrl0 = bus_write && (paddr_i == CTRL0_OFS);

    // Stages reset to the idle high level, so no false edge after reset
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trig_s1 <= 1'b1;
            trig_s2 <= 1'b1;
            trig_s3 <= 1'b1;
            trig_lvl <= 1'b1;
        end else begin
            trig_s1 <= ext_conv_trigger_in_i;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            trig_lvl <= next_trig_lvl;
        end
    end

    // Glitch filter: a pin change counts once two late stages agree
    always_comb begin
        next_trig_lvl = trig_lvl;
        if (trig_s2 == trig_s3) begin
            next_trig_lvl = trig_s3;
        end
        trig_fall = trig_lvl && (trig_s2 == trig_s3) && !trig_s3;
    end

    always_comb begin
        sw_start = wr_ctrl0 && pwdata_i[START_BIT] && !ctrl0[START_BIT]
            && !pwdata_i[EXT_TRIG_BIT];
        // Retrigger restarts even a running conversion
        ext_start = trig_fall && ctrl0[START_BIT] && ctrl0[EXT_TRIG_BIT]
            && !wr_ctrl0;
        stop = wr_ctrl0 && !pwdata_i[START_BIT];
        rearm = cif.done && repeats(cur_mode) && ctrl0[START_BIT] && !stop;
    end

    assign cif.start = sw_start || ext_start || rearm;
    assign cif.abort = stop;
    assign cif.div_sel = ctrl1[DIV_LSB +: DIV_W];
    assign cif.res10 = ctrl1[RES10_BIT];
    assign cif.sh_on = ctrl2[SH_BIT];

    // A pin start reuses stored settings, a write start takes the new ones
    always_comb begin
        sel_ch = ext_start ? ctrl0[CH_LSB +: CH_W] : pwdata_i[CH_LSB +: CH_W];
        sel_mode = ext_start ? ctrl0[MODE_LSB +: MODE_W] : pwdata_i[MODE_LSB +: MODE_W];
        sel_ext = ext_start || pwdata_i[EXT_TRIG_BIT];
    end

    always_comb begin
        next_ctrl0 = ctrl0;
        next_ctrl1 = ctrl1;
        next_ctrl2 = ctrl2;
        if (cif.done && !repeats(cur_mode) && !cur_ext) begin
            next_ctrl0[START_BIT] = 1'b0;
        end
        // Software write after the hardware clear, so a same-cycle write wins
        if (bus_write) begin
            case (paddr_i)
                CTRL0_OFS: next_ctrl0 = pwdata_i[7:0];
                CTRL1_OFS: next_ctrl1 = pwdata_i[7:0];
                CTRL2_OFS: next_ctrl2 = pwdata_i[7:0];
                default: next_ctrl2 = ctrl2;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl0 <= CTRL0_RST;
            ctrl1 <= CTRL1_RST;
            ctrl2 <= CTRL2_RST;
        end else begin
            ctrl0 <= next_ctrl0;
            ctrl1 <= next_ctrl1;
            ctrl2 <= next_ctrl2;
        end
    end

    always_comb begin
        next_irq = cif.done && !repeats(cur_mode);
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    always_comb begin
        next_cur_idx = cur_idx;
        next_cur_mode = cur_mode;
        next_cur_ext = cur_ext;
        next_ain = ain;
        if (cif.start && !rearm) begin
            next_cur_mode = sel_mode;
            next_cur_ext = sel_ext;
            next_cur_idx = sel_ch;
            next_ain = {1'b0, sel_ch};
            // Extended inputs reuse the first two result slots
            if (ctrl1[EXTA_BIT] && !ctrl1[EXTB_BIT]) begin
                next_ain = AIN_EXT_A;
                next_cur_idx = RES_IDX_EXT_A;
            end else if (!ctrl1[EXTA_BIT] && ctrl1[EXTB_BIT]) begin
                next_ain = AIN_EXT_B;
                next_cur_idx = RES_IDX_EXT_B;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur_idx <= '0;
            cur_mode <= MODE_ONE_SHOT;
            cur_ext <= 1'b0;
            ain <= '0;
        end else begin
            cur_idx <= next_cur_idx;
            cur_mode <= next_cur_mode;
            cur_ext <= next_cur_ext;
            ain <= next_ain;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
            assign res_we[g] = cif.done && (cur_idx == CH_W'(g));
        end
    endgenerate

    always_comb begin
        for (int i = 0; i < NUM_SLOTS; i++) begin
            next_res_mem[i] = res_we[i] ? cif.result : res_mem[i];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                res_mem[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                res_mem[i] <= next_res_mem[i];
            end
        end
    end

    assign idx_ofs = paddr_i - RES_BASE_OFS;

    // Read data captured in the setup phase, stable through the access
    always_comb begin
        next_rdata = rdata;
        if (bus_setup_rd) begin
            next_rdata = 32'h0000_0000;
            case (paddr_i)
                CTRL0_OFS: next_rdata[7:0] = ctrl0;
                CTRL1_OFS: next_rdata[7:0] = ctrl1;
                CTRL2_OFS: next_rdata[7:0] = ctrl2;
                STAT_OFS: begin
                    next_rdata[BUSY_BIT] = cif.busy;
                    next_rdata[LAST_CH_LSB +: CH_W] = cur_idx;
                end
                default: begin
                    if (is_res_addr(paddr_i)) begin
                        // Whole 10-bit result in the low bits of one word
                        next_rdata[RES_W-1:0] = res_mem[idx_ofs[4:2]];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Ladder cut when unused; software must connect before starting
    assign ladder_connect_o = ctrl1[LADDER_BIT];
    assign ain_sel_o = ain;
    assign sample_o = cif.sample;
    assign dac_code_o = cif.dac_code;
    assign conv_irq_o = irq;
endmodule

// ---- verif/analog_src_model.sv ----
`timescale 1ns/1ns
module analog_src_model
    import adc_seq_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic [AIN_W-1:0] ain_sel_i,
    input wire logic [RES_W-1:0] dac_code_i,
    output logic cmp_o,
    output logic trig_o
);
    // Distinct level per pin so a wrong slot or mux shows up
    function automatic logic [RES_W-1:0] level(input logic [AIN_W-1:0] a);
        return 10'h0A5 + 10'(a) * 10'h05B;
    endfunction
    assign cmp_o = level(ain_sel_i) >= dac_code_i;
    initial trig_o = 1'b1;
    task automatic fall();
        @(posedge ref_clk_i);
        trig_o <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        trig_o <= 1'b1;
    endtask
endmodule

// ---- verif/adc_seq_checker.sv ----
`timescale 1ns/1ns
module adc_seq_checker
    import adc_seq_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic ext_conv_trigger_in_i,
    input wire logic cmp_i,
    input wire logic ladder_connect_o,
    input wire logic [AIN_W-1:0] ain_sel_o,
    input wire logic sample_o,
    input wire logic [RES_W-1:0] dac_code_o,
    input wire logic conv_irq_o
);
    logic wr0;
    logic wr1;
    logic rep_mode;
    logic next_rep_mode;
    assign wr0 = psel_i && penable_i && pwrite_i && paddr_i == CTRL0_OFS;
    assign wr1 = psel_i && penable_i && pwrite_i && paddr_i == CTRL1_OFS;
    always_comb begin
        next_rep_mode = rep_mode;
        if (wr0) begin
            next_rep_mode = pwdata_i[START_BIT] && pwdata_i[MODE_LSB+:MODE_W] == MODE_REPEAT;
        end
    end
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rep_mode <= 1'b0;
        end else begin
            rep_mode <= next_rep_mode;
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_ladder_on;
        wr1 && pwdata_i[LADDER_BIT] |=> ladder_connect_o;
    endproperty
    a_ladder_on: assert property (p_ladder_on) else $error("ladder stays off");
    property p_ladder_off;
        wr1 && !pwdata_i[LADDER_BIT] |=> !ladder_connect_o;
    endproperty
    a_ladder_off: assert property (p_ladder_off) else $error("ladder stays on");
    property p_abort;
        wr0 && !pwdata_i[START_BIT] |-> ##2 (!sample_o && !conv_irq_o) [*4];
    endproperty
    a_abort: assert property (p_abort) else $error("stop did not halt");
    property p_irq_gap;
        conv_irq_o |=> !conv_irq_o [*8];
    endproperty
    a_irq_gap: assert property (p_irq_gap) else $error("irq too close");
    property p_rep_quiet;
        rep_mode |-> !conv_irq_o;
    endproperty
    a_rep_quiet: assert property (p_rep_quiet) else $error("irq in repeat");
    property p_ain_range;
        ain_sel_o <= AIN_EXT_B;
    endproperty
    a_ain_range: assert property (p_ain_range) else $error("bad mux code");
    property p_ain_stable;
        sample_o && $past(sample_o) |-> $stable(ain_sel_o);
    endproperty
    a_ain_stable: assert property (p_ain_stable) else $error("mux moved");
    property p_irq_idle;
        conv_irq_o |-> !sample_o;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("sampling at end");
    property p_slverr;
        psel_i && penable_i && paddr_i > RES_LAST_OFS |-> pslverr_o;
    endproperty
    a_slverr: assert property (p_slverr) else $error("no slave error");
    c_irq: cover property (conv_irq_o);
    c_rep: cover property (rep_mode && $rose(sample_o));
    c_trig: cover property ($fell(ext_conv_trigger_in_i));
endmodule
bind adc_seq_top adc_seq_checker u_adc_seq_checker (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .ext_conv_trigger_in_i(ext_conv_trigger_in_i), .cmp_i(cmp_i),
    .ladder_connect_o(ladder_connect_o), .ain_sel_o(ain_sel_o), .sample_o(sample_o),
    .dac_code_o(dac_code_o), .conv_irq_o(conv_irq_o));

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
module testbench
    import adc_seq_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, trig, cmp, ladder, sample, irq, err;
    logic [AIN_W-1:0] ain;
    logic [RES_W-1:0] dac;
    logic [31:0] rd;
    int error_cnt = 0;
    int n_compared = 0;
    always #25 ref_clk = ~ref_clk;
    adc_seq_top u_adc_seq_top (.ref_clk_i(ref_clk), .rstn_i(rstn), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .ext_conv_trigger_in_i(trig), .cmp_i(cmp), .ladder_connect_o(ladder),
        .ain_sel_o(ain), .sample_o(sample), .dac_code_o(dac), .conv_irq_o(irq));
    analog_src_model u_analog_src_model (.ref_clk_i(ref_clk), .ain_sel_i(ain),
        .dac_code_i(dac), .cmp_o(cmp), .trig_o(trig));
    function automatic logic [RES_W-1:0] lvl(input logic [3:0] a);
        return 10'h0A5 + 10'(a) * 10'h05B;
    endfunction
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("unexpected at %0t: no ready", $time);
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check(32'(k), 32'h1, "ready");
    endtask
    task automatic wait_irq(input int lim, output int n);
        n = 0;
        while (irq !== 1'b1) begin
            @(negedge ref_clk);
            n++;
            if (n > lim) begin
                $display("unexpected at %0t: no completion", $time);
                error_cnt++;
                end_sim();
            end
        end
    endtask
    task automatic t_reset();
        for (int i = 0; i < 3; i++) begin
            apb(0, 12'(4 * i), 32'h0);
            check(rd, 32'h0, "reset value");
        end
        check(ladder, 32'h0, "ladder");
        apb(1, CTRL1_OFS, 32'h20);
        @(negedge ref_clk);
        check(ladder, 32'h1, "ladder");
        apb(1, CTRL1_OFS, 32'h0);
        @(negedge ref_clk);
        check(ladder, 32'h0, "ladder");
        apb(0, 12'h030, 32'h0);
        check({rd[30:0], err}, 32'h1, "unmapped");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 5; m++) begin
            apb(1, CTRL0_OFS, 32'(m << MODE_LSB));
            apb(0, CTRL0_OFS, 32'h0);
            check(rd, 32'(m << MODE_LSB), "mode");
        end
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic t_oneshot(input logic [2:0] ch, input logic [7:0] c1, input logic sh,
        input int cyc, input logic [3:0] pin, input logic [2:0] slot);
        int n;
        apb(1, CTRL1_OFS, {24'h0, c1});
        apb(1, CTRL2_OFS, {31'h0, sh});
        apb(1, CTRL0_OFS, {29'h10, ch});
        // Resolution flipped mid-run must not change the length
        apb(1, CTRL1_OFS, {24'h0, c1 ^ 8'h08});
        check(ain, pin, "mux");
        wait_irq(cyc + 40, n);
        n += 3;
        if (n < cyc - 1 || n > cyc + 8) begin
            error_cnt++;
            $display("unexpected at %0t: length %0d want %0d", $time, n, cyc);
        end
        repeat (5) @(negedge ref_clk);
        check(sample, 32'h0, "one only");
        apb(0, CTRL0_OFS, 32'h0);
        check(rd, {29'h0, ch}, "flag");
        if (c1[RES10_BIT]) begin
            apb(0, RES_BASE_OFS + 12'(4 * slot), 32'h0);
            check(rd, {22'h0, lvl(pin)}, "result");
        end
    endtask
    task automatic t_repeat();
        int rises;
        int irqs;
        logic prev;
        apb(1, CTRL1_OFS, 32'h2A);
        apb(1, CTRL2_OFS, 32'h0);
        apb(1, CTRL0_OFS, 32'h8A);
        rises = 0;
        irqs = 0;
        prev = 1'b0;
        for (int k = 0; k < 230; k++) begin
            @(negedge ref_clk);
            rises += int'(sample === 1'b1 && !prev);
            irqs += int'(irq === 1'b1);
            prev = sample;
        end
        check(32'(rises >= 3), 32'h1, "restarts");
        check(32'(irqs), 32'h0, "repeat irq");
        apb(0, RES_BASE_OFS + 12'h008, 32'h0);
        check(rd, {22'h0, lvl(4'h2)}, "repeat result");
        apb(1, CTRL0_OFS, 32'h0);
        repeat (80) @(negedge ref_clk);
        check(sample, 32'h0, "stopped");
        apb(0, STAT_OFS, 32'h0);
        check(rd[BUSY_BIT], 32'h0, "busy");
    endtask
    task automatic t_ext();
        int n;
        apb(1, CTRL1_OFS, 32'h2A);
        apb(1, CTRL0_OFS, 32'hC4);
        repeat (70) @(negedge ref_clk);
        check(sample, 32'h0, "no edge yet");
        u_analog_src_model.fall();
        wait_irq(80, n);
        check(32'(n + 9 >= 59 && n + 9 <= 71), 32'h1, "ext length");
        apb(0, CTRL0_OFS, 32'h0);
        check(rd, 32'hC4, "flag kept");
        apb(0, RES_BASE_OFS + 12'h010, 32'h0);
        check(rd, {22'h0, lvl(4'h4)}, "ext result");
        u_analog_src_model.fall();
        repeat (11) @(posedge ref_clk);
        u_analog_src_model.fall();
        wait_irq(80, n);
        check(32'(n + 9 >= 59 && n + 9 <= 71), 32'h1, "retrigger");
        apb(1, CTRL0_OFS, 32'h0);
        repeat (10) @(posedge ref_clk);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_modes();
        t_oneshot(3'h5, 8'h2A, 1'b0, 59, 4'h5, 3'h5);
        t_oneshot(3'h1, 8'h21, 1'b0, 98, 4'h1, 3'h1);
        t_oneshot(3'h6, 8'h20, 1'b1, 112, 4'h6, 3'h6);
        t_oneshot(3'h3, 8'h6A, 1'b1, 33, AIN_EXT_A, RES_IDX_EXT_A);
        t_oneshot(3'h3, 8'hAA, 1'b0, 59, AIN_EXT_B, RES_IDX_EXT_B);
        t_repeat();
        t_ext();
        end_sim();
    end
endmodule
